/* File: dtcm_defs.svh */
// Register offsets, field positions, reset values and timing counts of the dual timer.
`ifndef DTCM_DEFS_SVH
`define DTCM_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DTCM_ADDR_IRQ_CONTROL  8'h88
`define DTCM_ADDR_MODE_SELECT  8'h89
`define DTCM_ADDR_T0_LOW       8'h8A
`define DTCM_ADDR_T1_LOW       8'h8B
`define DTCM_ADDR_T0_HIGH      8'h8C
`define DTCM_ADDR_T1_HIGH      8'h8D

// ----------------------------------------------------------------------
// Field positions of timer_irq_control
// ----------------------------------------------------------------------
`define DTCM_TCTL_TF1  7
`define DTCM_TCTL_TR1  6
`define DTCM_TCTL_TF0  5
`define DTCM_TCTL_TR0  4
`define DTCM_TCTL_IE1  3
`define DTCM_TCTL_IT1  2
`define DTCM_TCTL_IE0  1
`define DTCM_TCTL_IT0  0

// ----------------------------------------------------------------------
// Field positions of timer_mode_select, per timer nibble
// ----------------------------------------------------------------------
`define DTCM_TIMER_MODE_SELECT_NIBBLE    4
`define DTCM_TIMER_MODE_SELECT_GATE      3
`define DTCM_TIMER_MODE_SELECT_CT        2
`define DTCM_TIMER_MODE_SELECT_MODE_HI   1
`define DTCM_TIMER_MODE_SELECT_MODE_LO   0

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define DTCM_RST_BYTE       8'h00
`define DTCM_OSC_PER_MCYC   12
`define DTCM_PRESCALE_MAX   5'h1F
`define DTCM_BYTE_MAX       8'hFF

`endif

/* File: dtcm_pkg.sv */
// Types shared by the dual timer/counter block.
package dtcm_pkg;

    // ------------------------------------------------------------------
    // Operating modes, in mode field order
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DTCM_MODE_13BIT,
        DTCM_MODE_16BIT,
        DTCM_MODE_RELOAD,
        DTCM_MODE_SPLIT
    } dtcm_mode_e;

    // ------------------------------------------------------------------
    // Result of one count step
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic       ovf;
    } dtcm_step_s;

    // ------------------------------------------------------------------
    // Complete state of the block
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0][7:0] low;
        logic [1:0][7:0] high;
        logic [7:0]      mode_sel;
        logic [1:0]      run;
        logic [1:0]      ovf_flag;
        logic [1:0]      ext_flag;
        logic [1:0]      ext_type;
        logic [3:0]      mcyc_cnt;
        logic [1:0]      tpin_s1;
        logic [1:0]      tpin_s2;
        logic [1:0]      tpin_smp;
        logic [1:0]      ipin_s1;
        logic [1:0]      ipin_s2;
        logic [1:0]      ipin_prev;
        logic [7:0]      rdata;
    } dtcm_state_s;

endpackage

/* File: dtcm_timer.sv */
// Two timer/counters with four modes, pin gating and external interrupt flags.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`include "dtcm_defs.svh"

module dtcm_timer
    import dtcm_pkg::*;
#(
    parameter int MCYC_DIV = `DTCM_OSC_PER_MCYC
) (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RESET,
    // Register port
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    // Interrupt vector acknowledges from the core
    input  wire logic       ACK_TIMER0,
    input  wire logic       ACK_TIMER1,
    input  wire logic       ACK_EXT0,
    input  wire logic       ACK_EXT1,
    // Device pins
    input  wire logic       COUNT_INPUT_PIN_0,
    input  wire logic       COUNT_INPUT_PIN_1,
    input  wire logic       EXT_IRQ_PIN_0,
    input  wire logic       EXT_IRQ_PIN_1,
    // Flags towards the core
    output logic            TIMER0_OVERFLOW_FLAG,
    output logic            TIMER1_OVERFLOW_FLAG,
    output logic            EXT_IRQ0_FLAG,
    output logic            EXT_IRQ1_FLAG
);

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------
    localparam logic [3:0] MCYC_LAST = 4'(MCYC_DIV - 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    dtcm_state_s st_ff;
    dtcm_state_s nxt_st;

    // ------------------------------------------------------------------
    // One count step of a timer in a given mode
    // ------------------------------------------------------------------
    function automatic dtcm_step_s count_step(
        input dtcm_mode_e mode,
        input logic [7:0] low,
        input logic [7:0] high,
        input logic       inc
    );
        dtcm_step_s r;
        r.low  = low;
        r.high = high;
        r.ovf  = 1'b0;
        if (inc) begin
            case (mode)
                DTCM_MODE_13BIT: begin
                    // Low five bits form the divide-by-32 prescaler.
                    r.low[4:0] = low[4:0] + 5'h01;
                    if (low[4:0] == `DTCM_PRESCALE_MAX) begin
                        r.high = high + 8'h01;
                        r.ovf  = (high == `DTCM_BYTE_MAX);
                    end
                end
                DTCM_MODE_16BIT: begin
                    {r.high, r.low} = {high, low} + 16'h0001;
                    r.ovf = ({high, low} == 16'hFFFF);
                end
                DTCM_MODE_RELOAD: begin
                    if (low == `DTCM_BYTE_MAX) begin
                        r.low = high;
                        r.ovf = 1'b1;
                    end else begin
                        r.low = low + 8'h01;
                    end
                end
                DTCM_MODE_SPLIT: begin
                    r.low = low + 8'h01;
                    r.ovf = (low == `DTCM_BYTE_MAX);
                end
                default: begin
                    r.low = low;
                end
            endcase
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [1:0]       mcyc_tick;
        logic             tick;
        logic [1:0]       gate_en;
        logic [1:0]       ct_sel;
        logic [1:0]       pin_fall;
        logic [1:0]       inc;
        logic [1:0]       ovf_set;
        logic [1:0]       ext_edge;
        logic [1:0]       ack_ovf;
        logic [1:0]       ack_ext;
        logic             split0;
        logic             high0_ovf;
        dtcm_mode_e [1:0] mode;
        dtcm_step_s [1:0] res;

        nxt_st    = st_ff;
        mcyc_tick = 2'b00;
        gate_en   = 2'b00;
        ct_sel    = 2'b00;
        pin_fall  = 2'b00;
        inc       = 2'b00;
        ovf_set   = 2'b00;
        ext_edge  = 2'b00;
        res       = '0;
        mode      = '{DTCM_MODE_13BIT, DTCM_MODE_13BIT};
        ack_ovf   = {ACK_TIMER1, ACK_TIMER0};
        ack_ext   = {ACK_EXT1, ACK_EXT0};
        high0_ovf = 1'b0;
        tick      = 1'b0;
        split0    = 1'b0;

        // --------------------------------------------------------------
        // Pin synchronisers
        // --------------------------------------------------------------
        // The first stage feeds only the second.
        // The previous interrupt pin sample serves the falling edge detector.
        nxt_st.tpin_s1 = {COUNT_INPUT_PIN_1, COUNT_INPUT_PIN_0};
        nxt_st.tpin_s2 = st_ff.tpin_s1;
        nxt_st.ipin_s1 = {EXT_IRQ_PIN_1, EXT_IRQ_PIN_0};
        nxt_st.ipin_s2 = st_ff.ipin_s1;
        nxt_st.ipin_prev = st_ff.ipin_s2;

        // --------------------------------------------------------------
        // Machine cycle divider
        // --------------------------------------------------------------
        // The divider runs free from reset, so both timers share one tick.
        // Starting a timer therefore does not align its first count to the start.
        tick = (st_ff.mcyc_cnt == MCYC_LAST);
        if (tick) begin
            nxt_st.mcyc_cnt = 4'h0;
        end else begin
            nxt_st.mcyc_cnt = st_ff.mcyc_cnt + 4'h1;
        end
        mcyc_tick = {tick, tick};

        // --------------------------------------------------------------
        // Mode decode and count enables
        // --------------------------------------------------------------
        // A count pin level held for less than one machine cycle may be missed.
        // The gate uses the synchronised interrupt pin, two clocks behind the pin.
        split0 = (dtcm_mode_e'(st_ff.mode_sel[1:0]) == DTCM_MODE_SPLIT);

        for (int i = 0; i < 2; i++) begin
            mode[i] = dtcm_mode_e'(st_ff.mode_sel[i*`DTCM_TIMER_MODE_SELECT_NIBBLE +: 2]);
            ct_sel[i] = st_ff.mode_sel[i*`DTCM_TIMER_MODE_SELECT_NIBBLE + `DTCM_TIMER_MODE_SELECT_CT];
            // Count pin sampled once per machine cycle, high then low counts.
            if (tick) begin
                nxt_st.tpin_smp[i] = st_ff.tpin_s2[i];
                pin_fall[i] = st_ff.tpin_smp[i] & ~st_ff.tpin_s2[i];
            end
            gate_en[i] = st_ff.run[i] &
                (~st_ff.mode_sel[i*`DTCM_TIMER_MODE_SELECT_NIBBLE + `DTCM_TIMER_MODE_SELECT_GATE] |
                 st_ff.ipin_s2[i]);
            inc[i] = gate_en[i] & (ct_sel[i] ? pin_fall[i] : mcyc_tick[i]);
            // Falling edge on the interrupt pin between two samples.
            ext_edge[i] = st_ff.ipin_prev[i] & ~st_ff.ipin_s2[i];
        end

        // --------------------------------------------------------------
        // Timer 1 hold
        // --------------------------------------------------------------
        // Timer 1 in mode 11 holds its count.
        // Its run bit belongs to the high byte of timer 0 when timer 0 is in mode 11.
        if (mode[1] == DTCM_MODE_SPLIT) begin
            inc[1] = 1'b0;
        end

        // --------------------------------------------------------------
        // Count steps
        // --------------------------------------------------------------
        for (int i = 0; i < 2; i++) begin
            res[i] = count_step(mode[i], st_ff.low[i], st_ff.high[i], inc[i]);
            nxt_st.low[i]  = res[i].low;
            nxt_st.high[i] = res[i].high;
        end

        // --------------------------------------------------------------
        // Timer 0 split mode
        // --------------------------------------------------------------
        // Timer 0 split: high byte counts machine cycles under timer 1 run.
        // Timer 1's own overflow then raises no flag.
        if (split0) begin
            if (st_ff.run[1] & tick) begin
                nxt_st.high[0] = st_ff.high[0] + 8'h01;
                high0_ovf = (st_ff.high[0] == `DTCM_BYTE_MAX);
            end
            ovf_set[0] = res[0].ovf;
            ovf_set[1] = high0_ovf;
        end else begin
            ovf_set[0] = res[0].ovf;
            ovf_set[1] = res[1].ovf;
        end

        // --------------------------------------------------------------
        // Software writes
        // --------------------------------------------------------------
        // Software writes replace the count at once.
        // A count byte write wins over a count step in the same cycle.
        if (REG_WR) begin
            case (REG_ADDR)
                `DTCM_ADDR_T0_LOW:  nxt_st.low[0]  = REG_WDATA;
                `DTCM_ADDR_T1_LOW:  nxt_st.low[1]  = REG_WDATA;
                `DTCM_ADDR_T0_HIGH: nxt_st.high[0] = REG_WDATA;
                `DTCM_ADDR_T1_HIGH: nxt_st.high[1] = REG_WDATA;
                `DTCM_ADDR_MODE_SELECT: nxt_st.mode_sel = REG_WDATA;
                `DTCM_ADDR_IRQ_CONTROL: begin
                    // Run bits change only here; counts are left alone.
                    nxt_st.run[1]      = REG_WDATA[`DTCM_TCTL_TR1];
                    nxt_st.run[0]      = REG_WDATA[`DTCM_TCTL_TR0];
                    nxt_st.ovf_flag[1] = REG_WDATA[`DTCM_TCTL_TF1];
                    nxt_st.ovf_flag[0] = REG_WDATA[`DTCM_TCTL_TF0];
                    nxt_st.ext_flag[1] = REG_WDATA[`DTCM_TCTL_IE1];
                    nxt_st.ext_flag[0] = REG_WDATA[`DTCM_TCTL_IE0];
                    nxt_st.ext_type[1] = REG_WDATA[`DTCM_TCTL_IT1];
                    nxt_st.ext_type[0] = REG_WDATA[`DTCM_TCTL_IT0];
                end
                default: begin
                    nxt_st.mode_sel = st_ff.mode_sel;
                end
            endcase
        end

        // --------------------------------------------------------------
        // Flags
        // --------------------------------------------------------------
        // Flags: acknowledge clears an overflow or edge-mode flag, a hardware set in the same cycle wins.
        // A software write of zero also loses to a same-cycle hardware set.
        for (int i = 0; i < 2; i++) begin
            if (ack_ovf[i]) begin
                nxt_st.ovf_flag[i] = 1'b0;
            end
            if (ovf_set[i]) begin
                nxt_st.ovf_flag[i] = 1'b1;
            end
            if (st_ff.ext_type[i]) begin
                if (ack_ext[i]) begin
                    nxt_st.ext_flag[i] = 1'b0;
                end
                if (ext_edge[i]) begin
                    nxt_st.ext_flag[i] = 1'b1;
                end
            end else begin
                // Level mode: flag follows the low pin, acknowledge has no effect.
                nxt_st.ext_flag[i] = ~st_ff.ipin_s2[i];
            end
        end

        // --------------------------------------------------------------
        // Read data
        // --------------------------------------------------------------
        // Read data, presented in the cycle after the strobe.
        // Outside that cycle the read data return to zero.
        nxt_st.rdata = 8'h00;
        if (REG_RD) begin
            case (REG_ADDR)
                `DTCM_ADDR_T0_LOW:      nxt_st.rdata = st_ff.low[0];
                `DTCM_ADDR_T1_LOW:      nxt_st.rdata = st_ff.low[1];
                `DTCM_ADDR_T0_HIGH:     nxt_st.rdata = st_ff.high[0];
                `DTCM_ADDR_T1_HIGH:     nxt_st.rdata = st_ff.high[1];
                `DTCM_ADDR_MODE_SELECT: nxt_st.rdata = st_ff.mode_sel;
                `DTCM_ADDR_IRQ_CONTROL: begin
                    nxt_st.rdata[`DTCM_TCTL_TF1] = st_ff.ovf_flag[1];
                    nxt_st.rdata[`DTCM_TCTL_TR1] = st_ff.run[1];
                    nxt_st.rdata[`DTCM_TCTL_TF0] = st_ff.ovf_flag[0];
                    nxt_st.rdata[`DTCM_TCTL_TR0] = st_ff.run[0];
                    nxt_st.rdata[`DTCM_TCTL_IE1] = st_ff.ext_flag[1];
                    nxt_st.rdata[`DTCM_TCTL_IT1] = st_ff.ext_type[1];
                    nxt_st.rdata[`DTCM_TCTL_IE0] = st_ff.ext_flag[0];
                    nxt_st.rdata[`DTCM_TCTL_IT0] = st_ff.ext_type[0];
                end
                default: begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            st_ff           <= '0;
            // Idle pins read high so reset shows no edge and no low level.
            st_ff.tpin_s1   <= 2'b11;
            st_ff.tpin_s2   <= 2'b11;
            st_ff.tpin_smp  <= 2'b11;
            st_ff.ipin_s1   <= 2'b11;
            st_ff.ipin_s2   <= 2'b11;
            st_ff.ipin_prev <= 2'b11;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign REG_RDATA            = st_ff.rdata;
    assign TIMER0_OVERFLOW_FLAG = st_ff.ovf_flag[0];
    assign TIMER1_OVERFLOW_FLAG = st_ff.ovf_flag[1];
    assign EXT_IRQ0_FLAG        = st_ff.ext_flag[0];
    assign EXT_IRQ1_FLAG        = st_ff.ext_flag[1];

endmodule

/* File: dtcm_timer_props.sv */
// Port-level assertions for the dual timer/counter block.
`timescale 1ns/1ns

module dtcm_timer_props (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       RESET,
    // Register port and acknowledges
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic       ACK_TIMER0,
    input wire logic       ACK_EXT0,
    // Pins and flags
    input wire logic       EXT_IRQ_PIN_0,
    input wire logic       EXT_IRQ_PIN_1,
    input wire logic       TIMER0_OVERFLOW_FLAG,
    input wire logic       EXT_IRQ0_FLAG,
    input wire logic       EXT_IRQ1_FLAG
);
    logic       ctl_wr;
    logic       run0_ff;
    logic [1:0] type_ff;
    logic [3:0] pin0_ff;

    // Run and type bits change only by software writes, so they are shadowed here.
    assign ctl_wr = REG_WR && REG_ADDR == 8'h88;
    always_ff @(posedge CLK) begin
        pin0_ff <= {pin0_ff[2:0], EXT_IRQ_PIN_0};
        if (RESET) begin
            run0_ff <= 1'h0;
            type_ff <= 2'h0;
        end else if (ctl_wr) begin
            run0_ff <= REG_WDATA[4];
            type_ff <= {REG_WDATA[2], REG_WDATA[0]};
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data not zero outside its slot");
    chk_unmapped_rd: assert property (
        (REG_RD && (REG_ADDR < 8'h88 || REG_ADDR > 8'h8D)) |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    chk_mode_readback: assert property (
        REG_WR && REG_ADDR == 8'h89 ##2 REG_RD && REG_ADDR == 8'h89
        |=> REG_RDATA == $past(REG_WDATA, 3))
        else $error("mode select readback wrong");
    chk_level_ext0: assert property (
        (!type_ff[0] && $past(type_ff[0], 4) == 1'h0)
        |-> EXT_IRQ0_FLAG == !$past(EXT_IRQ_PIN_0, 3))
        else $error("level flag does not follow pin");
    chk_edge_ext1: assert property (
        (type_ff[1] && $past(type_ff[1], 4) && $past(EXT_IRQ_PIN_1, 4)
         && !$past(EXT_IRQ_PIN_1, 3)) |-> ##[0:2] EXT_IRQ1_FLAG)
        else $error("falling edge not flagged");
    chk_ext_ack_clr: assert property (
        (ACK_EXT0 && type_ff[0] && &pin0_ff && EXT_IRQ_PIN_0 && !ctl_wr) |=> !EXT_IRQ0_FLAG)
        else $error("edge flag not cleared by acknowledge");
    chk_ovf_ack_clr: assert property (
        (ACK_TIMER0 && !run0_ff && !ctl_wr) |=> !TIMER0_OVERFLOW_FLAG)
        else $error("overflow flag not cleared by acknowledge");
    chk_ovf_cause: assert property (
        $rose(TIMER0_OVERFLOW_FLAG) |-> $past(run0_ff) || $past(ctl_wr))
        else $error("overflow flag set while stopped");
endmodule

bind dtcm_timer dtcm_timer_props u_props (
    .CLK(CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ACK_TIMER0(ACK_TIMER0),
    .ACK_EXT0(ACK_EXT0), .EXT_IRQ_PIN_0(EXT_IRQ_PIN_0), .EXT_IRQ_PIN_1(EXT_IRQ_PIN_1),
    .TIMER0_OVERFLOW_FLAG(TIMER0_OVERFLOW_FLAG), .EXT_IRQ0_FLAG(EXT_IRQ0_FLAG),
    .EXT_IRQ1_FLAG(EXT_IRQ1_FLAG)
);

/* File: dtcm_core_model.sv */
// Core-side interrupt vectoring model that acknowledges pending flags.
`timescale 1ns/1ns

module dtcm_core_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Bench control
    input  wire logic       ack_en,
    input  wire logic       slow,
    // Flags in, acknowledges out
    input  wire logic [3:0] flags,
    output logic      [3:0] acks
);
    logic [2:0] wait_ff;

    // Vectors to every pending source once the latency has run out.
    always_ff @(posedge clk) begin
        if (reset || !ack_en || flags == 4'h0 || acks != 4'h0) begin
            wait_ff <= 3'h0;
            acks    <= 4'h0;
        end else if (wait_ff == (slow ? 3'h5 : 3'h0)) begin
            acks <= flags;
        end else begin
            wait_ff <= wait_ff + 3'h1;
        end
    end
endmodule

/* File: dtcm_timer_tb.sv */
// Self-checking bench of the dual timer/counter block.
`timescale 1ns/1ns

module dtcm_timer_tb;
    localparam int DIV = 4;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [16:0] p;
    logic [1:0]  tpin;
    logic [1:0]  ipin;
    logic        clk;
    logic        reset;
    logic        reg_wr;
    logic        reg_rd;
    logic        ack_en;
    logic        slow;
    wire  [3:0]  flg;
    wire  [3:0]  ack;
    integer      seed = 32'h6455C41E;
    int          error_cnt = 0;
    int          checks = 0;
    int          t;
    int          m;
    int          n;

    dtcm_timer #(.MCYC_DIV(DIV)) DUT (
        .CLK(clk), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .ACK_TIMER0(ack[0]), .ACK_TIMER1(ack[1]), .ACK_EXT0(ack[2]), .ACK_EXT1(ack[3]),
        .COUNT_INPUT_PIN_0(tpin[0]), .COUNT_INPUT_PIN_1(tpin[1]),
        .EXT_IRQ_PIN_0(ipin[0]), .EXT_IRQ_PIN_1(ipin[1]),
        .TIMER0_OVERFLOW_FLAG(flg[0]), .TIMER1_OVERFLOW_FLAG(flg[1]),
        .EXT_IRQ0_FLAG(flg[2]), .EXT_IRQ1_FLAG(flg[3]));
    dtcm_core_model core (.clk(clk), .reset(reset), .ack_en(ack_en), .slow(slow),
        .flags(flg), .acks(ack));

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
        rd(a, d0);
        chk(d0 & msk, exp & msk);
    endtask

    task automatic wait_flag(input int idx, input logic lvl);
        int k;
        k = 0;
        while (flg[idx] !== lvl && k < 400) begin
            @(posedge clk);
            k++;
        end
        chk({7'h00, flg[idx]}, {7'h00, lvl});
        if (k == 400) give_verdict();
    endtask

    // Each pulse is long enough to be seen high and low by whole machine cycles.
    task automatic pulse(input int pin, input int cnt);
        repeat (cnt) begin
            @(posedge clk);
            tpin[pin] <= 1'h0;
            repeat (3 * DIV) @(posedge clk);
            tpin[pin] <= 1'h1;
            repeat (3 * DIV) @(posedge clk);
        end
    endtask

    function automatic logic [16:0] predict(input int md, input logic [7:0] h,
                                            input logic [7:0] l, input int cnt);
        logic [16:0] r;
        r = {1'h0, h, l};
        repeat (cnt) begin
            if (md == 0) begin
                r[16] = r[16] | ({r[15:8], r[4:0]} == 13'h1FFF);
                {r[15:8], r[4:0]} = {r[15:8], r[4:0]} + 13'h0001;
            end else if (md == 1) begin
                r[16] = r[16] | (r[15:0] == 16'hFFFF);
                r[15:0] = r[15:0] + 16'h0001;
            end else begin
                r[16] = r[16] | (r[7:0] == 8'hFF);
                r[7:0] = (r[7:0] == 8'hFF) ? r[15:8] : r[7:0] + 8'h01;
            end
        end
        return r;
    endfunction

    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {reset, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'h1, 18'h00000};
        {tpin, ipin, ack_en, slow} = 6'h3C;
        repeat (4) @(posedge clk);
        reset <= 1'h0;
        for (int a = 8'h87; a <= 8'h8E; a++) rdchk(8'(a), 8'h00, 8'hFF);
        wr(8'h8E, 8'h5A);
        rdchk(8'h8E, 8'h00, 8'hFF);
        for (t = 0; t < 2; t++) begin
            wr(8'h89, 8'h09 << (4 * t));
            rdchk(8'h89, 8'h09 << (4 * t), 8'hFF);
            wr(8'h8A + 8'(t), 8'h00);
            wr(8'h8C + 8'(t), 8'h12);
            @(posedge clk);
            ipin[t] <= 1'h0;
            wr(8'h88, 8'h10 << (2 * t));
            repeat (10 * DIV) @(posedge clk);
            rdchk(8'h8A + 8'(t), 8'h00, 8'hFF);
            rdchk(8'h8C + 8'(t), 8'h12, 8'hFF);
            @(posedge clk);
            ipin[t] <= 1'h1;
            repeat (2 * DIV) @(posedge clk);
            rd(8'h8A + 8'(t), d1);
            repeat (10 * DIV - 2) @(posedge clk);
            rd(8'h8A + 8'(t), d0);
            chk(d0 - d1, 8'h0A);
            wr(8'h88, 8'h00);
        end
        for (int i = 0; i < 6; i++) begin
            t = i % 2;
            m = i / 2;
            hi = (m == 2) ? 8'($random(seed)) : 8'hFF;
            lo = 8'($random(seed)) | 8'hF8;
            n = 1 + ($random(seed) & 15);
            p = predict(m, hi, lo, n);
            wr(8'h89, 8'({2'h1, m[1:0]}) << (4 * t));
            wr(8'h8A + 8'(t), lo);
            wr(8'h8C + 8'(t), hi);
            wr(8'h88, 8'h10 << (2 * t));
            pulse(t, n);
            chk({7'h00, flg[t]}, {7'h00, p[16]});
            rdchk(8'h8A + 8'(t), p[7:0], (m == 0) ? 8'h1F : 8'hFF);
            rdchk(8'h8C + 8'(t), p[15:8], 8'hFF);
            wr(8'h88, 8'h00);
        end
        wr(8'h89, 8'h33);
        wr(8'h8C, 8'hFE);
        wr(8'h8A, 8'h40);
        wr(8'h8B, 8'h77);
        wr(8'h88, 8'h40);
        wait_flag(1, 1'h1);
        chk({7'h00, flg[0]}, 8'h00);
        rdchk(8'h8A, 8'h40, 8'hFF);
        rdchk(8'h8B, 8'h77, 8'hFF);
        wr(8'h88, 8'hA0);
        ack_en <= 1'h1;
        slow <= 1'h1;
        wait_flag(0, 1'h0);
        wait_flag(1, 1'h0);
        ack_en <= 1'h0;
        wr(8'h88, 8'h05);
        @(posedge clk);
        ipin <= 2'h0;
        wait_flag(2, 1'h1);
        wait_flag(3, 1'h1);
        @(posedge clk);
        ipin <= 2'h3;
        repeat (8) @(posedge clk);
        chk({6'h00, flg[3:2]}, 8'h03);
        ack_en <= 1'h1;
        slow <= 1'h0;
        wait_flag(2, 1'h0);
        wait_flag(3, 1'h0);
        ack_en <= 1'h0;
        wr(8'h88, 8'h00);
        @(posedge clk);
        ipin[0] <= 1'h0;
        wait_flag(2, 1'h1);
        ipin[0] <= 1'h1;
        wait_flag(2, 1'h0);
        give_verdict();
    end
endmodule
